//--- qdsl_dac_ctrl.sv
// load, update and clear control of the quad serial dac
`timescale 1ns/1ps
`default_nettype none
module qdsl_dac_ctrl
   import qdsl_pkg::*;
#(
   parameter int NUM_CH = NUM_CHAN,
   parameter int DATA_W = DATA_BITS,
   parameter int PKG_W  = PKG_ADDR_W
) (
   input  wire logic                           mclk,
   input  wire logic                           rst_n,
   input  wire logic                           frame_strobe_n,
   input  wire logic                           sclk,
   input  wire logic                           din,
   input  wire logic [PKG_W-1:0]               package_addr_pin,
   input  wire logic                           package_addr_enable,
   input  wire logic                           latch_update_n,
   input  wire logic                           force_clear_n,
   output logic      [NUM_CH-1:0][DATA_W-1:0]  dac_latch,
   output logic      [NUM_CH-1:0][DATA_W-1:0]  input_reg,
   output logic                                sense_ground_level_sel,
   output logic                                frame_accepted,
   output logic                                frame_rejected,
   output logic                                frame_short
);

   generate
      if (NUM_CH != NUM_CHAN || DATA_W != DATA_BITS || PKG_W != PKG_ADDR_W) begin : g_bad
         $error("qdsl_dac_ctrl: geometry must match the frame layout");
      end
   endgenerate

   // edge finders on synchronised levels
   function automatic logic fell(input logic prev, input logic cur);
      fell = prev & ~cur;
   endfunction

   function automatic logic rose(input logic prev, input logic cur);
      rose = ~prev & cur;
   endfunction

   // package address filter
   function automatic logic addr_ok(input logic [PKG_W-1:0] want,
                                    input logic [PKG_W-1:0] got,
                                    input logic             any);
      addr_ok = any | (want == got);
   endfunction

   // two-stage synchronisers for all pins
   qdsl_link_t         link_s1_q;
   qdsl_link_t         link_s2_q;
   qdsl_link_t         link_prev_q;
   logic [PKG_W-1:0]   pa_s1_q;
   logic [PKG_W-1:0]   pa_s2_q;
   logic               package_addr_enable_s1_q;
   logic               package_addr_enable_s2_q;
   logic               latch_update_n_s1_q;
   logic               latch_update_n_s2_q;
   logic               clr_s1_q;
   logic               clr_s2_q;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         link_s1_q   <= '{strobe_n: 1'b1, sclk: 1'b0, din: 1'b0};
         link_s2_q   <= '{strobe_n: 1'b1, sclk: 1'b0, din: 1'b0};
         link_prev_q <= '{strobe_n: 1'b1, sclk: 1'b0, din: 1'b0};
      end else begin
         link_s1_q   <= '{strobe_n: frame_strobe_n, sclk: sclk, din: din};
         link_s2_q   <= link_s1_q;
         link_prev_q <= link_s2_q;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pa_s1_q   <= '0;
         pa_s2_q   <= '0;
         package_addr_enable_s1_q <= 1'b0;
         package_addr_enable_s2_q <= 1'b0;
      end else begin
         pa_s1_q   <= package_addr_pin; // RL3
         pa_s2_q   <= pa_s1_q;
         package_addr_enable_s1_q <= package_addr_enable;
         package_addr_enable_s2_q <= package_addr_enable_s1_q;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         latch_update_n_s1_q <= 1'b1;
         latch_update_n_s2_q <= 1'b1;
         clr_s1_q  <= 1'b1;
         clr_s2_q  <= 1'b1;
      end else begin
         latch_update_n_s1_q <= latch_update_n;
         latch_update_n_s2_q <= latch_update_n_s1_q;
         clr_s1_q  <= force_clear_n;
         clr_s2_q  <= clr_s1_q;
      end
   end

   // link edges
   logic strobe_fall;
   logic strobe_rise;
   logic sclk_fall;

   always_comb begin
      strobe_fall = fell(link_prev_q.strobe_n, link_s2_q.strobe_n);
      strobe_rise = rose(link_prev_q.strobe_n, link_s2_q.strobe_n);
      sclk_fall   = fell(link_prev_q.sclk, link_s2_q.sclk);
   end

   // frame sequencer
   qdsl_state_t state_q;
   qdsl_state_t state_d;

   always_comb begin
      state_d = state_q;
      case (state_q)
         QDSL_IDLE: begin
            if (strobe_fall) begin
               state_d = QDSL_SHIFT; // RL1
            end
         end
         QDSL_SHIFT: begin
            if (strobe_rise) begin
               state_d = QDSL_END;
            end
         end
         QDSL_END: begin
            state_d = QDSL_IDLE;
         end
         default: begin
            state_d = QDSL_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= QDSL_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // shift register and bit count
   qdsl_frame_t shift_q;
   logic [4:0]  count_q;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         shift_q <= '0;
         count_q <= CNT_RESET;
      end else if (strobe_fall) begin
         count_q <= CNT_RESET; // RL1
      end else if (state_q == QDSL_SHIFT && !link_s2_q.strobe_n && sclk_fall) begin
         shift_q <= {shift_q[FRAME_BITS-2:0], link_s2_q.din}; // RL12
         if (count_q != CNT_FULL) begin
            count_q <= count_q + 5'h01;
         end
      end
   end

   // frame decision at strobe rise
   logic        frame_end;
   logic        frame_full;
   logic        frame_match;
   logic        take;
   qdsl_event_t ev_d;
   qdsl_event_t ev_q;

   always_comb begin
      frame_end   = (state_q == QDSL_SHIFT) && strobe_rise;
      frame_full  = (count_q == CNT_FULL);
      frame_match = addr_ok(pa_s2_q, shift_q.pkg, package_addr_enable_s2_q); // RL4 RL5
      take        = frame_end && frame_full && frame_match; // RL2
      ev_d.accepted    = take;
      ev_d.rejected    = frame_end && frame_full && !frame_match;
      ev_d.short_frame = frame_end && !frame_full;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ev_q <= '0;
      end else begin
         ev_q <= ev_d;
      end
   end

   // input registers with this frame applied
   logic [NUM_CH-1:0][DATA_W-1:0] in_d;
   logic [NUM_CH-1:0][DATA_W-1:0] in_q;

   always_comb begin
      in_d = in_q;
      if (take) begin
         in_d[shift_q.chan] = shift_q.data; // RL2 RL5
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         in_q <= {NUM_CH{CODE_RESET}};
      end else begin
         in_q <= in_d; // RL6
      end
   end

   // dac latches, load strobe ignored while clear is low
   logic [NUM_CH-1:0][DATA_W-1:0] latch_q;
   logic                          load_ok;

   always_comb begin
      load_ok = !latch_update_n_s2_q && clr_s2_q; // RL11
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         latch_q <= {NUM_CH{CODE_RESET}};
      end else if (load_ok) begin
         latch_q <= in_d; // RL7 RL8
      end
   end

   // output clamp: set at once by clear, released by a load
   logic clamp_q;

   always_ff @(posedge mclk or negedge rst_n or negedge force_clear_n) begin
      if (!rst_n) begin
         clamp_q <= CLAMP_RESET;
      end else if (!force_clear_n) begin
         clamp_q <= 1'b1; // RL9 RL11
      end else if (load_ok) begin
         clamp_q <= 1'b0; // RL10
      end
   end

   always_comb begin
      dac_latch              = latch_q;
      input_reg              = in_q;
      sense_ground_level_sel = clamp_q;
      frame_accepted         = ev_q.accepted;
      frame_rejected         = ev_q.rejected;
      frame_short            = ev_q.short_frame;
   end

endmodule
`default_nettype wire

//--- qdsl_pkg.sv
// constants, types and frame layout for the quad dac serial load block
// What this block does
// RL1 - The host lowers the frame strobe before sending bits; only bits after its fall count.
// RL2 - On the frame strobe rising edge the 24-bit shift register goes to a channel input register.
// RL3 - The package address comes from five static address pins tied high or low.
// RL4 - With package address enable low, a frame is taken only if its package address matches.
// RL5 - With package address enable high, the package address is ignored, the channel is still used.
// RL6 - While the load strobe is high, frames change only input registers, never latches or outputs.
// RL7 - When the load strobe goes low, all four input registers are copied into their latches together.
// RL8 - With the load strobe low during a frame, the addressed latch updates at the frame strobe rise.
// RL9 - When clear goes low, all outputs switch to the sense ground level at once, without any clock.
// RL10 - After clear rises, outputs stay at sense ground until the load strobe is low, then show latches.
// RL11 - While clear is low, the load strobe is ignored and outputs stay at sense ground.
// RL12 - A frame is sent msb first as package address, channel address and data, one bit per sclk cycle; the block shifts in a bit only on sclk falling edges.
package qdsl_pkg;

   // frame geometry
   localparam int FRAME_BITS  = 24;
   localparam int PKG_ADDR_W  = 5;
   localparam int CHAN_ADDR_W = 2;
   localparam int DATA_BITS   = 14;
   localparam int NUM_CHAN    = 4;
   localparam int SPARE_W     = FRAME_BITS - PKG_ADDR_W - CHAN_ADDR_W - DATA_BITS;

   // field positions, msb first
   localparam int PKG_LSB  = FRAME_BITS - PKG_ADDR_W;
   localparam int CHAN_LSB = PKG_LSB - CHAN_ADDR_W;
   localparam int DATA_LSB = 0;

   // synchroniser depth and reset values
   localparam int                 SYNC_STAGES = 2;
   localparam logic [13:0]        CODE_RESET  = 14'h0000;
   localparam logic [4:0]         CNT_RESET   = 5'h00;
   localparam logic [4:0]         CNT_FULL    = 5'h18;
   localparam logic               CLAMP_RESET = 1'b1;

   typedef struct packed {
      logic [PKG_ADDR_W-1:0]  pkg;
      logic [CHAN_ADDR_W-1:0] chan;
      logic [SPARE_W-1:0]     spare;
      logic [DATA_BITS-1:0]   data;
   } qdsl_frame_t;

   typedef struct packed {
      logic strobe_n;
      logic sclk;
      logic din;
   } qdsl_link_t;

   typedef struct packed {
      logic accepted;
      logic rejected;
      logic short_frame;
   } qdsl_event_t;

   typedef enum logic [1:0] {
      QDSL_IDLE,
      QDSL_SHIFT,
      QDSL_END
   } qdsl_state_t;

endpackage

//--- qdsl_dac_ctrl_asserts.sv
// assertions on the ports of the quad dac load control
`timescale 1ns/1ps
`default_nettype none
module qdsl_dac_ctrl_asserts
   import qdsl_pkg::*;
#(
   parameter int NUM_CH = NUM_CHAN,
   parameter int DATA_W = DATA_BITS
) (
   input wire logic                          mclk,
   input wire logic                          rst_n,
   input wire logic                          frame_strobe_n,
   input wire logic                          package_addr_enable,
   input wire logic                          latch_update_n,
   input wire logic                          force_clear_n,
   input wire logic [NUM_CH-1:0][DATA_W-1:0] dac_latch,
   input wire logic [NUM_CH-1:0][DATA_W-1:0] input_reg,
   input wire logic                          sense_ground_level_sel,
   input wire logic                          frame_accepted,
   input wire logic                          frame_rejected
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   property p_clr; !force_clear_n |-> sense_ground_level_sel; endproperty
   a_clr: assert property (p_clr) else $error("not clamped");
   property p_hold; latch_update_n[*5] |-> $stable(dac_latch); endproperty
   a_hold: assert property (p_hold) else $error("latch moved");
   property p_load;
      (!latch_update_n && force_clear_n)[*6] |-> dac_latch == input_reg && !sense_ground_level_sel;
   endproperty
   a_load: assert property (p_load) else $error("no load");
   property p_clrhold;
      !force_clear_n[*4] |-> $stable(dac_latch) && sense_ground_level_sel;
   endproperty
   a_clrhold: assert property (p_clrhold) else $error("load under clear");
   property p_unclamp;
      $fell(sense_ground_level_sel) |-> force_clear_n && !$past(latch_update_n, 2);
   endproperty
   a_unclamp: assert property (p_unclamp) else $error("early unclamp");
   property p_acc; frame_accepted |-> $past(frame_strobe_n, 2); endproperty
   a_acc: assert property (p_acc) else $error("accept without rise");
   property p_pulse; frame_accepted |=> !frame_accepted; endproperty
   a_pulse: assert property (p_pulse) else $error("long pulse");
   property p_rej; frame_rejected |-> !package_addr_enable; endproperty
   a_rej: assert property (p_rej) else $error("reject while enabled");
   c_imm: cover property (frame_accepted && !latch_update_n);
   c_rej: cover property (frame_rejected);
   c_clr: cover property (!force_clear_n && !latch_update_n);
endmodule
bind qdsl_dac_ctrl qdsl_dac_ctrl_asserts #(.NUM_CH(NUM_CH), .DATA_W(DATA_W)) chk_u (
   .mclk, .rst_n, .frame_strobe_n, .package_addr_enable, .latch_update_n, .force_clear_n,
   .dac_latch, .input_reg, .sense_ground_level_sel, .frame_accepted, .frame_rejected);
`default_nettype wire

//--- qdsl_host_model.sv
// host model driving framed serial writes
`timescale 1ns/1ps
`default_nettype none
module qdsl_host_model (
   input  wire logic mclk,
   output logic      frame_strobe_n,
   output logic      sclk,
   output logic      din
);
   initial begin
      frame_strobe_n = 1'b1;
      sclk = 1'b1;
      din = 1'b0;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   // low n bits of f, msb first, taken on sclk fall
   task automatic send(input logic [23:0] f, input int n);
      frame_strobe_n = 1'b0;
      wt(4);
      for (int i = n - 1; i >= 0; i--) begin
         din = f[i];
         sclk = 1'b1;
         wt(4);
         sclk = 1'b0;
         wt(4);
      end
      frame_strobe_n = 1'b1;
      sclk = 1'b1;
      din = ~din;
      wt(8);
   endtask
endmodule
`default_nettype wire

//--- qdsl_dac_ctrl_test.sv
// self-checking bench for the quad dac load control
`timescale 1ns/1ps
`default_nettype none
module qdsl_dac_ctrl_test;
   import qdsl_pkg::*;
   logic [4:0] my_pa = 5'h15;
   logic mclk = 1'b0, rst_n = 1'b0, pae = 1'b0, ld_n = 1'b1, clr_n = 1'b1;
   logic fs_n, sclk, din, acc, rej, sht, sel;
   logic [3:0][13:0] lat, inr, e_in, e_lat;
   int miscompares = 0, n_checks = 0, n_acc = 0, n_rej = 0, n_sht = 0;
   int e_acc = 0, e_rej = 0, cyc = 0;
   qdsl_dac_ctrl dut_u (.mclk, .rst_n, .frame_strobe_n(fs_n), .sclk, .din,
      .package_addr_pin(my_pa), .package_addr_enable(pae), .latch_update_n(ld_n),
      .force_clear_n(clr_n), .dac_latch(lat), .input_reg(inr), .sense_ground_level_sel(sel),
      .frame_accepted(acc), .frame_rejected(rej), .frame_short(sht));
   qdsl_host_model host_u (.mclk, .frame_strobe_n(fs_n), .sclk, .din);
   always #20 mclk = ~mclk;
   always @(posedge mclk) begin
      n_acc += acc;
      n_rej += rej;
      n_sht += sht;
      cyc++;
      if (cyc > 20000) begin
         miscompares++;
         conclude();
      end
   end
   task automatic conclude();
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [55:0] got, input logic [55:0] exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t got %0h exp %0h", $time, got, exp);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   function automatic logic hit(input logic [4:0] p);
      return pae || p == my_pa;
   endfunction
   task automatic frame(input logic [4:0] p, input logic [1:0] c, input logic [13:0] d);
      qdsl_frame_t f;
      f = '{pkg: p, chan: c, spare: '0, data: d};
      host_u.send(f, 24);
      if (hit(p)) begin
         e_in[c] = d;
         e_acc++;
      end else e_rej++;
      if (!ld_n && clr_n) e_lat = e_in;
      chk(inr, e_in);
      chk(lat, e_lat);
   endtask
   initial begin
      void'($urandom(85213));
      my_pa = 5'($urandom);
      e_in = '0;
      e_lat = '0;
      repeat (4) @(posedge mclk);
      #1 rst_n = 1'b1;
      wt(3);
      chk(lat, 56'h0);
      chk(sel, 1'b1);
      for (int i = 0; i < 10; i++) begin
         pae = 1'($urandom);
         frame(($urandom % 3 == 0) ? 5'($urandom) : my_pa, 2'($urandom), 14'($urandom));
      end
      chk(sel, 1'b1);
      ld_n = 1'b0;
      wt(8);
      e_lat = e_in;
      chk(lat, e_lat);
      chk(sel, 1'b0);
      for (int c = 0; c < 4; c++) frame(my_pa, 2'(c), c[0] ? 14'h3FFF : 14'h0000);
      pae = 1'b0;
      frame(~my_pa, 2'h1, 14'h2AAA);
      pae = 1'b1;
      frame(~my_pa, 2'h3, 14'h1555);
      pae = 1'b0;
      host_u.send(24'hFFFFFF, 10);
      chk(inr, e_in);
      clr_n = 1'b0;
      #5 chk(sel, 1'b1);
      wt(1);
      frame(my_pa, 2'h2, 14'h1234);
      chk(sel, 1'b1);
      ld_n = 1'b1;
      clr_n = 1'b1;
      wt(8);
      chk(sel, 1'b1);
      ld_n = 1'b0;
      wt(8);
      e_lat = e_in;
      chk(lat, e_lat);
      chk(sel, 1'b0);
      chk(n_acc, e_acc);
      chk(n_rej, e_rej);
      chk(n_sht, 1);
      conclude();
   end
endmodule
`default_nettype wire
